// file: rtl/dkhp_host_port.sv
// Processor I/O transfer port of the flexible-disk controller
`timescale 1ns/10ps
`default_nettype none
module dkhp_host_port (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic bus_init_in,
    // Processor instruction side
    input wire logic iot_valid_in,
    input wire logic [11:0] iot_instr_in,
    input wire logic [11:0] ac_in,
    output logic [11:0] ac_out,
    output logic ac_load_out,
    output logic skip_out,
    output logic irq_out,
    // Controller engine side
    output logic [11:0] cmd_out,
    output logic cmd_valid_out,
    output logic [11:0] word_out,
    output logic word_ack_out,
    output logic init_start_out,
    output logic xfer_req_out,
    input wire logic need_word_in,
    input wire logic [2:0] need_role_in,
    input wire logic give_word_in,
    input wire logic [11:0] word_in,
    input wire logic func_done_in,
    input wire logic [4:0] fault_in,
    input wire logic [11:0] status_in,
    input wire logic init_done_in
);
    typedef struct packed {
        logic [11:0] iface;
        logic [11:0] cmd;
        logic [7:0] err_code;
        dkhp_pkg::dkhp_role_t role;
        logic to_host;
        logic eight_bit;
        logic cmd_hi_wait;
        logic xfer_req;
        logic err;
        logic done;
        logic ie;
        logic [11:0] ac;
        logic ac_load;
        logic skip;
        logic irq;
        logic cmd_valid;
        logic ack;
        logic init_start;
    } dkhp_state_t;

    dkhp_state_t st_reg;
    dkhp_state_t st_next;
    logic is_iot;
    logic [2:0] op;
    logic [7:0] code;
    logic [11:0] stat;
    logic engine_idle;

    assign is_iot = iot_valid_in && (iot_instr_in[11:6] == dkhp_pkg::IOT_DEVICE);
    assign op = iot_instr_in[2:0];
    // Engine events overwrite the interface register, so checks wait for a quiet cycle
    assign engine_idle = !need_word_in && !give_word_in && !func_done_in && !init_done_in;

    always_comb begin
        st_next = st_reg;
        st_next.ac_load = 1'b0;
        st_next.skip = 1'b0;
        st_next.irq = 1'b0;
        st_next.cmd_valid = 1'b0;
        st_next.ack = 1'b0;
        st_next.init_start = 1'b0;
        code = (fault_in < 5'(dkhp_pkg::FAULT_COUNT)) ? dkhp_pkg::ERR_TABLE[fault_in]
            : dkhp_pkg::ERR_NONE;
        stat = status_in;
        if (fault_in == dkhp_pkg::FAULT_DATA_CRC) begin
            stat[dkhp_pkg::ST_DATA_CRC_BIT] = 1'b1;
        end
        if (fault_in == dkhp_pkg::FAULT_PARITY) begin
            stat[dkhp_pkg::ST_PARITY_BIT] = 1'b1;
        end
        // Clears from the processor come first so engine events win
        if (is_iot) begin
            case (op)
                dkhp_pkg::OP_LOAD_COMMAND: begin
                    st_next.iface = ac_in;
                    st_next.ac = dkhp_pkg::WORD_ZERO;
                    st_next.ac_load = 1'b1;
                    st_next.role = dkhp_pkg::ROLE_COMMAND;
                    st_next.to_host = 1'b0;
                    st_next.eight_bit = ac_in[dkhp_pkg::CMD_WORD_LEN_BIT];
                    st_next.done = 1'b0;
                    st_next.err = 1'b0;
                    // In 8-bit mode the upper command nibble follows by transfer-data
                    st_next.cmd_hi_wait = ac_in[dkhp_pkg::CMD_WORD_LEN_BIT];
                    if (ac_in[dkhp_pkg::CMD_WORD_LEN_BIT]) begin
                        st_next.iface = {4'h0, ac_in[7:0]};
                        st_next.xfer_req = 1'b1;
                    end else begin
                        st_next.cmd = ac_in;
                        st_next.cmd_valid = 1'b1;
                    end
                end
                dkhp_pkg::OP_TRANSFER_DATA: begin
                    if (st_reg.to_host || st_reg.done) begin
                        st_next.ac = st_reg.eight_bit && !st_reg.done
                            ? (ac_in | {4'h0, st_reg.iface[7:0]}) : st_reg.iface;
                        st_next.ac_load = 1'b1;
                    end else if (st_reg.cmd_hi_wait) begin
                        st_next.cmd = {ac_in[3:0], st_reg.iface[7:0]};
                        st_next.iface = st_next.cmd;
                        st_next.cmd_hi_wait = 1'b0;
                        st_next.cmd_valid = 1'b1;
                    end else begin
                        st_next.iface = st_reg.eight_bit ? {4'h0, ac_in[7:0]} : ac_in;
                    end
                    if (!st_reg.done) begin
                        st_next.ack = 1'b1;
                    end
                end
                dkhp_pkg::OP_SKIP_XFER_REQ: begin
                    st_next.skip = st_reg.xfer_req;
                    st_next.xfer_req = 1'b0;
                end
                dkhp_pkg::OP_SKIP_ERROR: begin
                    st_next.skip = st_reg.err;
                    st_next.err = 1'b0;
                end
                dkhp_pkg::OP_SKIP_DONE: begin
                    st_next.skip = st_reg.done;
                    st_next.done = 1'b0;
                end
                dkhp_pkg::OP_INTERRUPT_CTL: begin
                    st_next.ie = ac_in[dkhp_pkg::AC_IE_BIT];
                end
                dkhp_pkg::OP_INITIALIZE: begin
                    st_next.ie = 1'b0;
                    st_next.init_start = 1'b1;
                    st_next.done = 1'b0;
                    st_next.err = 1'b0;
                    st_next.xfer_req = 1'b0;
                    st_next.cmd_hi_wait = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (bus_init_in) begin
            st_next.ie = 1'b0;
            st_next.init_start = 1'b1;
        end
        if (need_word_in) begin
            st_next.xfer_req = 1'b1;
            st_next.to_host = 1'b0;
            st_next.role = dkhp_pkg::dkhp_role_t'(need_role_in);
        end
        if (give_word_in) begin
            st_next.xfer_req = 1'b1;
            st_next.to_host = 1'b1;
            st_next.iface = word_in;
            st_next.role = dkhp_pkg::ROLE_DATA;
        end
        if (func_done_in) begin
            st_next.done = 1'b1;
            st_next.to_host = 1'b0;
            st_next.err_code = code;
            if (code != dkhp_pkg::ERR_NONE) begin
                st_next.err = 1'b1;
            end
            if (st_reg.cmd[3:1] == dkhp_pkg::FN_READ_ERROR) begin
                st_next.iface = {4'h0, code};
                st_next.role = dkhp_pkg::ROLE_ERROR_CODE;
            end else begin
                st_next.iface = stat;
                st_next.role = dkhp_pkg::ROLE_STATUS;
            end
        end
        if (init_done_in) begin
            // Status clears, then only the initialize-done bit stands
            st_next.iface = dkhp_pkg::WORD_ZERO;
            st_next.iface[dkhp_pkg::ST_INIT_DONE_BIT] = 1'b1;
            st_next.role = dkhp_pkg::ROLE_STATUS;
            st_next.err_code = dkhp_pkg::ERR_NONE;
            st_next.done = 1'b1;
            st_next.to_host = 1'b0;
        end
        // Edge, not level, so a held done flag cannot storm the processor
        st_next.irq = st_next.ie && st_next.done && !st_reg.done;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ac_out = st_reg.ac;
    assign ac_load_out = st_reg.ac_load;
    assign skip_out = st_reg.skip;
    assign irq_out = st_reg.irq;
    assign cmd_out = st_reg.cmd;
    assign cmd_valid_out = st_reg.cmd_valid;
    assign word_out = st_reg.iface;
    assign word_ack_out = st_reg.ack;
    assign init_start_out = st_reg.init_start;
    assign xfer_req_out = st_reg.xfer_req;

    sequence load_cmd_s;
        is_iot && op == dkhp_pkg::OP_LOAD_COMMAND && engine_idle;
    endsequence

    sequence xdr_s;
        is_iot && op == dkhp_pkg::OP_TRANSFER_DATA;
    endsequence

    sequence byte_load_s;
        is_iot && op == dkhp_pkg::OP_LOAD_COMMAND && engine_idle
        && ac_in[dkhp_pkg::CMD_WORD_LEN_BIT];
    endsequence

    sequence skip_req_s;
        is_iot && op == dkhp_pkg::OP_SKIP_XFER_REQ && !need_word_in && !give_word_in;
    endsequence

    load_clears_ac_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        load_cmd_s |=> ac_load_out && ac_out == 12'h000 && word_out[7:0] == $past(ac_in[7:0]))
        else $error("load command did not clear accumulator");
    nop_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_NOP |=> !ac_load_out && !skip_out)
        else $error("no-op instruction had an effect");
    skip_req_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        skip_req_s |=> skip_out == $past(st_reg.xfer_req) && !xfer_req_out)
        else $error("skip on request wrong");
    err_has_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(st_reg.err) |-> st_reg.done)
        else $error("error flag without done");
    skip_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_SKIP_DONE && !func_done_in && !init_done_in
        |=> skip_out == $past(st_reg.done) && !st_reg.done)
        else $error("skip on done wrong");
    irq_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        irq_out |-> st_reg.done ##1 !irq_out)
        else $error("interrupt not a single pulse");
    irq_cause_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(st_reg.done) && st_reg.ie |-> irq_out)
        else $error("done rise lost its interrupt");
    ie_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_INTERRUPT_CTL && !bus_init_in
        |=> st_reg.ie == $past(ac_in[0]))
        else $error("interrupt enable not taken from bit 11");
    init_clears_ie_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        bus_init_in |=> !st_reg.ie && init_start_out)
        else $error("initialize left interrupts enabled");
    init_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        init_done_in |=> word_out == 12'h004 && st_reg.done)
        else $error("initialize-done status wrong");
    eight_or_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_TRANSFER_DATA && st_reg.to_host && st_reg.eight_bit
        && !st_reg.done |=> ac_out == ($past(ac_in) | {4'h0, $past(st_reg.iface[7:0])}))
        else $error("8-bit read not ORed");
    crc_code_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        func_done_in && fault_in == dkhp_pkg::FAULT_DATA_CRC && !init_done_in
        |=> st_reg.err_code == 8'h80 && st_reg.err)
        else $error("data CRC code wrong");
    xdr_ack_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (!st_reg.done) |=> word_ack_out)
        else $error("transfer-data while busy not acknowledged");
    write_keeps_ac_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (!st_reg.to_host && !st_reg.done) |=> !ac_load_out)
        else $error("write to controller changed accumulator");
    write_full_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (!st_reg.to_host && !st_reg.done && !st_reg.cmd_hi_wait && !st_reg.eight_bit
        && engine_idle) |=> word_out == $past(ac_in))
        else $error("12-bit write word wrong");
    write_byte_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (!st_reg.to_host && !st_reg.done && !st_reg.cmd_hi_wait && st_reg.eight_bit
        && engine_idle) |=> word_out == {4'h0, $past(ac_in[7:0])})
        else $error("8-bit write word wrong");
    read_full_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (st_reg.to_host && !st_reg.done && !st_reg.eight_bit)
        |=> ac_load_out && ac_out == $past(word_out))
        else $error("12-bit read not a full load");
    done_status_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 st_reg.done |=> ac_load_out && ac_out == $past(word_out))
        else $error("status not returned after done");
    skip_err_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_SKIP_ERROR && !func_done_in
        |=> skip_out == $past(st_reg.err) && !st_reg.err)
        else $error("skip on error wrong");
    byte_cmd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        byte_load_s |=> xfer_req_out && !cmd_valid_out
        && word_out[7:0] == $past(ac_in[7:0]))
        else $error("8-bit command low part not held");
    hi_nibble_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        xdr_s ##0 (st_reg.cmd_hi_wait && !st_reg.to_host && !st_reg.done)
        |=> cmd_valid_out && cmd_out == {$past(ac_in[3:0]), $past(word_out[7:0])})
        else $error("8-bit command upper bits wrong");
    cmd_full_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        load_cmd_s ##0 (!ac_in[dkhp_pkg::CMD_WORD_LEN_BIT])
        |=> cmd_valid_out && cmd_out == $past(ac_in))
        else $error("12-bit command not taken whole");
    parity_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        func_done_in && fault_in == dkhp_pkg::FAULT_PARITY && !init_done_in
        && st_reg.cmd[3:1] != dkhp_pkg::FN_READ_ERROR
        |=> word_out[dkhp_pkg::ST_PARITY_BIT] && st_reg.err_code == dkhp_pkg::ERR_PARITY)
        else $error("parity fault report wrong");
    prog_init_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        is_iot && op == dkhp_pkg::OP_INITIALIZE |=> !st_reg.ie && init_start_out)
        else $error("programmed initialize wrong");
endmodule
`default_nettype wire

// file: rtl/dkhp_pkg.sv
// Constants and types for the disk controller processor I/O port
//
// Contract
// - Decode I/O codes 67x0-67x7, middle digit ignored; 67x0 does nothing.
// - Load-command copies the accumulator to the interface register, then clears it.
// - Transfer-data moves one word; the device picks the direction from context.
// - Transfer-data word size follows the last selected 8- or 12-bit mode.
// - Transfer-data while not done acknowledges the word taken or given.
// - Writes leave the accumulator; reads replace 12 bits or OR in 8 bits.
// - After completion, transfer-data returns error/status to the accumulator.
// - Skip-on-request skips when the request flag is set and clears it.
// - Skip-on-error skips when the error flag is set, then clears it.
// - Setting the error flag always sets done; done may set alone.
// - Skip-on-done skips when the done flag is set, then clears it.
// - With interrupts enabled, request one interrupt when done first rises.
// - Interrupt control sets enable from accumulator bit 11.
// - Clear-all, bus initialize and programmed initialize clear interrupt enable.
// - Initialize seeks, self-tests, loads a sector, clears status, sets bit 9.
// - One interface register stands for six logical registers by protocol step.
// - Error codes: 0 none, 010/020 init, 030/050 track 0, 040 bad track.
// - Codes 070 and 110 to 170 report seek and header failures.
// - Data CRC gives 200 and status bit 0; cable parity 210 and bit 1.
// - Codes 100, 230, 240, 250, 260, 350, 370 for other faults.
// - Command bit 5 clear selects 12-bit words, set selects 8-bit words.
package dkhp_pkg;
    // Processor bit n sits at vector index 11-n
    localparam logic [5:0] IOT_DEVICE = 6'h37;
    localparam logic [2:0] OP_NOP = 3'h0;
    localparam logic [2:0] OP_LOAD_COMMAND = 3'h1;
    localparam logic [2:0] OP_TRANSFER_DATA = 3'h2;
    localparam logic [2:0] OP_SKIP_XFER_REQ = 3'h3;
    localparam logic [2:0] OP_SKIP_ERROR = 3'h4;
    localparam logic [2:0] OP_SKIP_DONE = 3'h5;
    localparam logic [2:0] OP_INTERRUPT_CTL = 3'h6;
    localparam logic [2:0] OP_INITIALIZE = 3'h7;
    localparam int CMD_WORD_LEN_BIT = 6;
    localparam int AC_IE_BIT = 0;
    localparam int ST_INIT_DONE_BIT = 2;
    localparam int ST_DATA_CRC_BIT = 11;
    localparam int ST_PARITY_BIT = 10;
    localparam logic [2:0] FN_READ_ERROR = 3'h7;
    localparam logic [11:0] WORD_ZERO = 12'h000;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_DATA_CRC = 8'h80;
    localparam logic [7:0] ERR_PARITY = 8'h88;
    localparam int FAULT_COUNT = 23;
    // Fault index from the engine to octal code: 000,010,020,030,040,050,070,100,110,
    // 120,130,140,150,160,170,200,210,230,240,250,260,350,370
    localparam logic [7:0] ERR_TABLE [FAULT_COUNT] = '{
        8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58,
        8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88, 8'h98, 8'ha0, 8'ha8, 8'hb0,
        8'he8, 8'hf8};
    localparam logic [4:0] FAULT_DATA_CRC = 5'h0f;
    localparam logic [4:0] FAULT_PARITY = 5'h10;

    typedef enum logic [2:0] {
        ROLE_COMMAND = 3'h0,
        ROLE_TRACK = 3'h1,
        ROLE_SECTOR = 3'h3,
        ROLE_DATA = 3'h2,
        ROLE_STATUS = 3'h6,
        ROLE_ERROR_CODE = 3'h7
    } dkhp_role_t;
endpackage

// file: test/dkhp_cpu_model.sv
// Processor model: accumulator and I/O instruction drive
`timescale 1ns/10ps
`default_nettype none
module dkhp_cpu_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Bench requests
    input wire logic go_in,
    input wire logic [2:0] op_in,
    input wire logic [2:0] mid_in,
    input wire logic set_in,
    input wire logic [11:0] set_val_in,
    // Port side
    input wire logic [11:0] ac_res_in,
    input wire logic ac_load_in,
    output logic iot_valid_out,
    output logic [11:0] iot_instr_out,
    output logic [11:0] ac_out
);
    logic [11:0] ac_reg;
    logic [11:0] instr;
    assign instr = {dkhp_pkg::IOT_DEVICE, mid_in, op_in};
    // Idle bus shows the inverse, never a stale instruction
    assign iot_instr_out = go_in ? instr : ~instr;
    assign iot_valid_out = go_in;
    assign ac_out = set_in ? set_val_in : ac_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ac_reg <= 12'h000;
        end else if (ac_load_in) begin
            ac_reg <= ac_res_in;
        end else if (set_in) begin
            ac_reg <= set_val_in;
        end
    end
endmodule
`default_nettype wire

// file: test/test_disk_ctrl_iot_host_port.sv
// Self-checking bench for the processor I/O port
`timescale 1ns/10ps
`default_nettype none
module test_disk_ctrl_iot_host_port;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic bus_init_in = 1'b0;
    logic go = 1'b0;
    logic set = 1'b0;
    logic [2:0] op = 3'h0;
    logic [2:0] mid = 3'h0;
    logic [11:0] set_val = 12'h000;
    logic iot_valid_in, ac_load_out, skip_out, irq_out, cmd_valid_out, word_ack_out;
    logic init_start_out, xfer_req_out;
    logic [11:0] iot_instr_in, ac_in, ac_out, cmd_out, word_out;
    logic need_word_in = 1'b0;
    logic give_word_in = 1'b0;
    logic func_done_in = 1'b0;
    logic init_done_in = 1'b0;
    logic [2:0] need_role_in = 3'h0;
    logic [11:0] word_in = 12'h000;
    logic [11:0] status_in = 12'h000;
    logic [4:0] fault_in = 5'h00;
    int seed, bad_count, n_checks, cycles, i;
    logic [14:0] q[$];
    logic [11:0] w, v;
    logic [7:0] codes [1:22] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h38, 8'h40, 8'h48,
        8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88, 8'h98, 8'ha0, 8'ha8,
        8'hb0, 8'he8, 8'hf8};
    always #4 sys_clk_in = ~sys_clk_in;
    dkhp_cpu_model i_cpu (.sys_clk_in, .rst_n_in, .go_in(go), .op_in(op), .mid_in(mid),
        .set_in(set), .set_val_in(set_val), .ac_res_in(ac_out), .ac_load_in(ac_load_out),
        .iot_valid_out(iot_valid_in), .iot_instr_out(iot_instr_in), .ac_out(ac_in));
    dkhp_host_port i_dut (.sys_clk_in, .rst_n_in, .bus_init_in, .iot_valid_in,
        .iot_instr_in, .ac_in, .ac_out, .ac_load_out, .skip_out, .irq_out, .cmd_out,
        .cmd_valid_out, .word_out, .word_ack_out, .init_start_out, .xfer_req_out,
        .need_word_in, .need_role_in, .give_word_in, .word_in, .func_done_in, .fault_in,
        .status_in, .init_done_in);
    task automatic chk(input string nm, input logic [14:0] s, input logic [14:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic note(input logic [2:0] k, input logic [11:0] val);
        q.push_back({k, val});
    endtask
    task automatic take(input logic [2:0] k, input logic [11:0] val);
        logic [14:0] e;
        e = (q.size() > 0) ? q.pop_front() : 15'h7fff;
        chk("result", {k, val}, e);
    endtask
    task automatic iot(input logic [2:0] o, input logic [11:0] a);
        go = 1'b1;
        op = o;
        mid = 3'($random(seed));
        set = 1'b1;
        set_val = a;
        @(posedge sys_clk_in);
        #1;
        go = 1'b0;
        set = 1'b0;
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic ev(input logic [1:0] k, input logic [11:0] val, input logic [4:0] f);
        give_word_in = (k == 2'h0);
        need_word_in = (k == 2'h1);
        func_done_in = (k == 2'h2);
        init_done_in = (k == 2'h3);
        word_in = val;
        status_in = val;
        fault_in = f;
        need_role_in = f[2:0];
        @(posedge sys_clk_in);
        #1;
        {give_word_in, need_word_in, func_done_in, init_done_in} = 4'h0;
        word_in = ~val;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Results are sampled well after the edge so registered outputs have settled
    always @(posedge sys_clk_in) begin
        #2;
        if (cmd_valid_out) take(3'h1, cmd_out);
        if (ac_load_out && ac_out !== ac_in) take(3'h2, ac_out);
        if (word_ack_out) take(3'h3, 12'h000);
        if (skip_out) take(3'h4, 12'h000);
        if (irq_out) take(3'h5, 12'h000);
        if (init_start_out) take(3'h6, 12'h000);
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        seed = 65;
        repeat (6) @(posedge sys_clk_in);
        #1;
        rst_n_in = 1'b1;
        chk("idle", {xfer_req_out, irq_out, skip_out, ac_load_out}, 15'h0000);
        w = 12'($random(seed)) | 12'h001;
        w[6] = 1'b0;
        note(3'h1, w);
        note(3'h2, 12'h000);
        iot(3'h1, w);
        chk("iface", word_out, w);
        iot(3'h0, 12'hfff);
        iot(3'h3, 12'h000);
        $display("load test over");
        w = 12'($random(seed)) | 12'h001;
        ev(2'h0, w, 5'h00);
        chk("xreq", xfer_req_out, 1'b1);
        note(3'h4, 12'h000);
        iot(3'h3, 12'h000);
        chk("xreq", xfer_req_out, 1'b0);
        note(3'h2, w);
        note(3'h3, 12'h000);
        iot(3'h2, 12'h000);
        ev(2'h1, 12'h000, {2'h0, dkhp_pkg::ROLE_DATA});
        note(3'h4, 12'h000);
        iot(3'h3, 12'h000);
        w = 12'($random(seed));
        note(3'h3, 12'h000);
        iot(3'h2, w);
        chk("wr", word_out, w);
        $display("12-bit test over");
        w = 12'($random(seed)) | 12'h041;
        note(3'h2, 12'h000);
        iot(3'h1, w);
        chk("xreq", xfer_req_out, 1'b1);
        note(3'h4, 12'h000);
        iot(3'h3, 12'h000);
        v = 12'($random(seed));
        note(3'h1, {v[3:0], w[7:0]});
        note(3'h3, 12'h000);
        iot(3'h2, v);
        w = 12'($random(seed)) | 12'h001;
        ev(2'h0, w, 5'h00);
        note(3'h4, 12'h000);
        iot(3'h3, 12'h000);
        v = {4'($random(seed)), 8'h00};
        note(3'h2, v | {4'h0, w[7:0]});
        note(3'h3, 12'h000);
        iot(3'h2, v);
        ev(2'h1, 12'h000, {2'h0, dkhp_pkg::ROLE_DATA});
        note(3'h4, 12'h000);
        iot(3'h3, 12'h000);
        v = 12'($random(seed));
        note(3'h3, 12'h000);
        iot(3'h2, v);
        chk("wr8", word_out, {4'h0, v[7:0]});
        $display("8-bit test over");
        iot(3'h6, 12'h001);
        note(3'h1, 12'h00e);
        note(3'h2, 12'h000);
        iot(3'h1, 12'h00e);
        for (i = 1; i < 23; i++) begin
            note(3'h5, 12'h000);
            ev(2'h2, 12'($random(seed)), 5'(i));
            note(3'h2, {4'h0, codes[i]});
            iot(3'h2, 12'hfff);
            note(3'h4, 12'h000);
            iot(3'h4, 12'h000);
            iot(3'h4, 12'h000);
            note(3'h4, 12'h000);
            iot(3'h5, 12'h000);
            iot(3'h5, 12'h000);
        end
        note(3'h1, 12'h002);
        note(3'h2, 12'h000);
        iot(3'h1, 12'h002);
        for (i = 0; i < 3; i++) begin
            w = 12'($random(seed)) & 12'h3ff;
            note(3'h5, 12'h000);
            ev(2'h2, w, (i == 0) ? 5'h00 : (i == 1) ? dkhp_pkg::FAULT_DATA_CRC : 5'h10);
            v = (i == 1) ? 12'h800 : (i == 2) ? 12'h400 : 12'h000;
            chk("status", word_out, w | v);
            if (i > 0) note(3'h4, 12'h000);
            iot(3'h4, 12'h000);
            note(3'h4, 12'h000);
            iot(3'h5, 12'h000);
        end
        $display("fault test over");
        iot(3'h6, 12'h000);
        ev(2'h2, 12'h000, 5'h00);
        note(3'h4, 12'h000);
        iot(3'h5, 12'h000);
        iot(3'h6, 12'h001);
        bus_init_in = 1'b1;
        note(3'h6, 12'h000);
        @(posedge sys_clk_in);
        #1;
        bus_init_in = 1'b0;
        ev(2'h2, 12'h000, 5'h00);
        note(3'h4, 12'h000);
        iot(3'h5, 12'h000);
        iot(3'h6, 12'h001);
        note(3'h6, 12'h000);
        iot(3'h7, 12'h000);
        ev(2'h3, 12'h000, 5'h00);
        @(posedge sys_clk_in);
        #1;
        chk("initdone", word_out[dkhp_pkg::ST_INIT_DONE_BIT], 1'b1);
        chk("pending", 15'(q.size()), 15'h0000);
        $display("control test over");
        end_of_test();
    end
endmodule
`default_nettype wire
